// ==== dv/csbp_peer.sv ====
// Behavioural far-side peripheral of the serial port.
// Assumes it sees the resolved clock pin and the port's data out.
`timescale 1ns/100ps
`default_nettype none
module csbp_peer (
   input  wire logic        sck_w,   // Resolved clock pin level.
   input  wire logic        so_i,    // Port data out.
   input  wire logic        sync_i,  // Restarts the outgoing word.
   input  wire logic [7:0]  pat_i,   // Word sent back.
   output logic             si_o,    // Port data in.
   output logic      [63:0] cap_o    // Bits taken in, newest on top.
);
   logic [2:0] k_ff = 3'h0;  // Next outgoing bit.
   initial si_o = 1'b1;
   initial cap_o = 64'h0;
   // Sample on the rising pin edge, where the port must hold its bit steady.
   always @(posedge sck_w) cap_o <= {so_i, cap_o[63:1]};
   // Present a fresh bit each fall, so a port sampling early sees the old one.
   always @(negedge sck_w or posedge sync_i) begin
      if (sync_i) k_ff <= 3'h0;
      else begin
         si_o <= pat_i[k_ff];
         k_ff <= k_ff + 3'h1;
      end
   end
endmodule : csbp_peer
`default_nettype wire

// ==== dv/csbp_port_properties.sv ====
// Pin-level checks on the buffered serial port.
// Assumes it sees only the port's top-level pins; bound in at the foot.
`timescale 1ns/100ps
`default_nettype none
module csbp_port_properties
   import csbp_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        irq_o,
   input wire logic        so_o,
   input wire logic        si_i,
   input wire logic        sck_i,
   input wire logic        sck_o,
   input wire logic        sck_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request that the slave has not yet answered.
   wire logic req = cyc_i && stb_i && !ack_o;
   property p_ack_next; req |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_wo_zero;
      req && !we_i && adr_i[15:3] == CSBP_IDX_CTL1[13:1] |=> dat_o == 32'h0;
   endproperty
   a_wo_zero: assert property (p_wo_zero) else $error("control read not zero");
   property p_so_rise; $rose(sck_o) |-> $stable(so_o); endproperty
   a_so_rise: assert property (p_so_rise) else $error("data moved on rise");
   property p_half; sck_oe_o && $changed(sck_o) |-> $past(sck_o, 8) == $past(sck_o); endproperty
   a_half: assert property (p_half) else $error("clock half too short");
   property p_irq_fall; $fell(irq_o) |-> $past(cyc_i && stb_i && we_i); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   property p_irq_rise; $rose(irq_o) |-> sck_o; endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq mid bit");
   property p_abort;
      req && we_i && sel_i[0] && adr_i[15:2] == CSBP_IDX_CTL1 && dat_i[CSBP_C1_ABORT]
         |-> ##[1:3] sck_o;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left clock low");
   c_write: cover property (req && we_i);
   c_irq:   cover property ($rose(irq_o));
   c_shift: cover property ($fell(sck_o));
endmodule : csbp_port_properties
bind csbp_port csbp_port_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .irq_o(irq_o), .so_o(so_o), .si_i(si_i), .sck_i(sck_i), .sck_o(sck_o),
   .sck_oe_o(sck_oe_o));
`default_nettype wire

// ==== dv/csbp_port_tb.sv ====
// Self-checking bench of the buffered serial port with its far-side peer.
// Assumes the Wishbone map and one-cycle answer of the port's note.
`timescale 1ns/100ps
`default_nettype none
module csbp_port_tb;
   import csbp_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [15:0] adr_i = 16'h0;
   logic [31:0] dat_i = 32'h0;
   logic        sync  = 1'b0;    // Peer word restart.
   logic [7:0]  pat   = 8'h96;   // Word the peer returns.
   logic [31:0] dat_o;
   logic        ack_o, irq_o, so_o, si_i, sck_o, sck_oe_o;
   logic [63:0] cap;
   int          n_fail = 0;
   int          samples_checked = 0;
   // The pin follows the far-side clock ext_sck whenever the port does not drive it.
   logic        ext_sck = 1'b1;  // Far-side clock, used when the external source is picked.
   wire logic   sck_w = sck_oe_o ? sck_o : ext_sck;
   always #2.5 clk_i = ~clk_i;
   csbp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
      .so_o(so_o), .si_i(si_i), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o));
   csbp_peer peer_u (.sck_w(sck_w), .so_i(so_o), .sync_i(sync), .pat_i(pat), .si_o(si_i),
      .cap_o(cap));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One classic cycle, held until ack is sampled high.
   task automatic bus(input logic w, input logic [13:0] ix, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {ix, 2'b00};
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      if (n >= 20) n_fail++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [13:0] ix, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, ix, d, q);
   endtask : wr
   task automatic rd(input logic [13:0] ix, input logic [7:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, ix, 8'h00, q);
      chk(nm, {24'h0, e}, q);
   endtask : rd
   task automatic wait_irq(input int lim);
      for (int n = 0; n < lim && irq_o !== 1'b1; n++) @(posedge clk_i);
      chk("irq", 32'h1, {31'h0, irq_o});
   endtask : wait_irq
   task automatic go(input logic [2:0] m);
      wr(CSBP_IDX_ISTAT, 8'h03);
      wr(CSBP_IDX_CTL1, {2'b10, m, 3'h5});
   endtask : go
   task automatic t_regs;
      wr(CSBP_IDX_BUF0 + 14'h3, 8'h5a);
      rd(CSBP_IDX_BUF0 + 14'h3, 8'h5a, "buffer");
      wr(CSBP_IDX_CTL2, 8'h1f);
      rd(CSBP_IDX_CTL2, 8'h00, "count reg");
      rd(14'h1f92, 8'h00, "unmapped");
      wr(CSBP_IDX_IMASK, 8'h01);
      rd(CSBP_IDX_IMASK, 8'h01, "mask");
   endtask : t_regs
   // Two bytes out, then the wait, the interrupt's mask and clear, abort and reuse.
   task automatic t_tx8;
      wr(CSBP_IDX_BUF0, 8'ha5);
      wr(CSBP_IDX_BUF0 + 14'h1, 8'h3c);
      wr(CSBP_IDX_CTL2, 8'h01);
      go(CSBP_M_TX8);
      wait_irq(700);
      chk("tx8 words", 32'h3ca5, {16'h0, cap[63:48]});
      repeat (40) @(posedge clk_i);
      chk("clock halted", 32'h1, {31'h0, sck_o});
      rd(CSBP_IDX_STAT, 8'h03, "status waiting");
      wr(CSBP_IDX_IMASK, 8'h00);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wr(CSBP_IDX_IMASK, 8'h01);
      wr(CSBP_IDX_ISTAT, 8'h01);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      wr(CSBP_IDX_CTL1, {2'b01, CSBP_M_TX8, 3'h5});
      rd(CSBP_IDX_STAT, 8'h00, "aborted");
      rd(CSBP_IDX_ISTAT, 8'h02, "ended event");
      wr(CSBP_IDX_BUF0, 8'h0f);
      wr(CSBP_IDX_BUF0 + 14'h1, 8'hf0);
      go(CSBP_M_TX8);
      wait_irq(700);
      chk("count kept", 32'hf00f, {16'h0, cap[63:48]});
      wr(CSBP_IDX_CTL1, {2'b01, CSBP_M_TX4, 3'h5});
   endtask : t_tx8
   // Eight nibbles; the upper halves must never reach the pin.
   task automatic t_tx4;
      for (int i = 0; i < 8; i++) wr(CSBP_IDX_BUF0 + 14'(i), 8'hf0 | 8'(i));
      wr(CSBP_IDX_CTL2, 8'h07);
      go(CSBP_M_TX4);
      wait_irq(1200);
      chk("tx4 words", 32'h76543210, cap[63:32]);
      wr(CSBP_IDX_CTL1, {2'b01, CSBP_M_RX4, 3'h5});
   endtask : t_tx4
   task automatic t_rx(input logic [2:0] m, input logic [7:0] e);
      sync <= 1'b1;
      wr(CSBP_IDX_BUF0, 8'hff);
      sync <= 1'b0;
      wr(CSBP_IDX_CTL2, 8'h00);
      go(m);
      wait_irq(400);
      rd(CSBP_IDX_BUF0, e, "rx word");
      wr(CSBP_IDX_CTL1, {2'b01, m, 3'h5});
   endtask : t_rx
   // Two words with frame code one: the second word ends one transfer time late.
   task automatic t_wait;
      sync <= 1'b1;
      wr(CSBP_IDX_BUF0, 8'h33);
      sync <= 1'b0;
      wr(CSBP_IDX_BUF0 + 14'h1, 8'hcc);
      wr(CSBP_IDX_CTL2, 8'h09);
      go(CSBP_M_TRX8);
      repeat (300) @(posedge clk_i);
      chk("irq before frame end", 32'h0, {31'h0, irq_o});
      wait_irq(150);
      chk("trx8 words", 32'hcc33, {16'h0, cap[63:48]});
      rd(CSBP_IDX_BUF0 + 14'h1, 8'h96, "trx8 second word");
      wr(CSBP_IDX_CTL1, {2'b01, CSBP_M_TRX8, 3'h5});
   endtask : t_wait
   // External clock: the far side drives the pin, eight pulses move one byte each way.
   task automatic t_ext;
      sync <= 1'b1;
      wr(CSBP_IDX_BUF0, 8'h69);
      sync <= 1'b0;
      wr(CSBP_IDX_CTL2, 8'h00);
      wr(CSBP_IDX_ISTAT, 8'h03);
      wr(CSBP_IDX_CTL1, {2'b10, CSBP_M_TRX8, CSBP_CLK_EXT});
      chk("pin released", 32'h0, {31'h0, sck_oe_o});
      repeat (8) begin
         repeat (8) @(posedge clk_i);
         ext_sck <= 1'b0;
         repeat (8) @(posedge clk_i);
         ext_sck <= 1'b1;
      end
      wait_irq(20);
      chk("ext sent", 32'h69, {24'h0, cap[63:56]});
      rd(CSBP_IDX_BUF0, 8'h96, "ext received");
      wr(CSBP_IDX_CTL1, {2'b01, CSBP_M_TRX8, 3'h5});
   endtask : t_ext
   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial begin
      #100000;
      n_fail++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_tx8;
      t_tx4;
      t_rx(CSBP_M_RX4, 8'h06);
      t_rx(CSBP_M_RX8, 8'h96);
      t_wait;
      t_ext;
      conclude;
   end
endmodule : csbp_port_tb
`default_nettype wire

// ==== hw/csbp_port.sv ====
// Buffered clocked serial port with a classic Wishbone register slave.
// Assumes every input is synchronous to clk_i and the external serial
// clock is far slower than clk_i, so edges are found by plain sampling.
`timescale 1ns/100ps
`default_nettype none
module csbp_port
   import csbp_pkg::*;
(
   input  wire logic        clk_i,     // 200 MHz system clock.
   input  wire logic        rst_i,     // Synchronous reset, active high.
   input  wire logic        cyc_i,     // Wishbone cycle.
   input  wire logic        stb_i,     // Wishbone strobe.
   input  wire logic        we_i,      // Wishbone write enable.
   input  wire logic [15:0] adr_i,     // Wishbone byte address.
   input  wire logic [3:0]  sel_i,     // Wishbone byte selects.
   input  wire logic [31:0] dat_i,     // Wishbone write data.
   output logic      [31:0] dat_o,     // Wishbone read data.
   output logic             ack_o,     // Wishbone acknowledge.
   output logic             irq_o,     // Level interrupt request.
   output logic             so_o,      // Serial data out.
   input  wire logic        si_i,      // Serial data in.
   input  wire logic        sck_i,     // Clock pin level in.
   output logic             sck_o,     // Clock pin drive level.
   output logic             sck_oe_o   // Clock pin drive enable.
);
   csbp_regs_t r_ff;   // All state of the block.
   csbp_regs_t nxt_r;  // Next value of the state.

   // Combinational helpers.
   logic        req;      // New bus request this cycle.
   logic        wr;       // Write taking effect.
   logic        rd;       // Read taking effect.
   logic [13:0] idx_a;    // Word index of the address.
   logic        buf_hit;  // Address hits the buffer.
   logic [2:0]  buf_sel;  // Buffer byte addressed.
   logic        is_tx;    // Mode transmits.
   logic        is_rx;    // Mode receives.
   logic        is_four;  // Four-bit words.
   logic        ext;      // External clock selected.
   logic        half;     // Internal half-period tick.
   logic        lead;     // Leading edge of the serial clock.
   logic        trail;    // Trailing edge of the serial clock.
   logic [2:0]  lastbit;  // Last bit index of a word.
   logic [6:0]  gaplim;   // Half periods of frame wait.
   logic        go;       // Software wrote start with the port idle.
   logic [2:0]  nidx;     // Word to load next.
   logic        wend;     // Word completed.

   // Decode, mode and edge helpers.
   always_comb begin
      req     = cyc_i & stb_i & ~r_ff.ack;
      wr      = req & we_i & sel_i[0];
      rd      = req & ~we_i;
      idx_a   = adr_i[15:2];
      buf_hit = (idx_a >= CSBP_IDX_BUF0) && (idx_a <= CSBP_IDX_BUF7);
      buf_sel = adr_i[4:2];
      is_tx   = (r_ff.mode == CSBP_M_TX8) || (r_ff.mode == CSBP_M_TX4) ||
                (r_ff.mode == CSBP_M_TRX8);
      is_rx   = (r_ff.mode == CSBP_M_RX8) || (r_ff.mode == CSBP_M_RX4) ||
                (r_ff.mode == CSBP_M_TRX8);
      is_four = (r_ff.mode == CSBP_M_TX4) || (r_ff.mode == CSBP_M_RX4);
      ext     = (r_ff.clksel == CSBP_CLK_EXT);
      // Codes above five have no mask; the reserved code never ticks.
      half    = (r_ff.clksel <= 3'h5) &&
                ((r_ff.div & CSBP_HALF_MASK[r_ff.clksel]) ==
                 CSBP_HALF_MASK[r_ff.clksel]);
      // Leading edge is the pin falling, trailing the pin rising.
      lead    = ext ? (r_ff.sck_prev & ~sck_i) : (half & r_ff.sck);
      trail   = ext ? (~r_ff.sck_prev & sck_i) : (half & ~r_ff.sck);
      lastbit = is_four ? 3'h3 : 3'h7;
      // Extra wait is (2^code - 1) transfer times.
      gaplim  = 7'((32'(1) << r_ff.waitc) - 1) * 7'(CSBP_TD_HALVES);
      go      = wr && (idx_a == CSBP_IDX_CTL1) && dat_i[CSBP_C1_START] &&
                ~r_ff.start && (r_ff.st == CSBP_IDLE);
      nidx    = (r_ff.idx == r_ff.nwords) ? 3'h0 : r_ff.idx + 3'h1;
      wend    = (r_ff.st == CSBP_RUN) && trail && (r_ff.bitc == lastbit);
   end

   // Next state: bus slave, registers, sequencer and interrupts.
   always_comb begin
      nxt_r      = r_ff;
      nxt_r.ack  = req;
      nxt_r.abort = 1'b0;
      nxt_r.div  = r_ff.div + 12'h001;
      nxt_r.sck_prev = sck_i;

      // Read data; write-only controls read as zero.
      if (rd) begin
         nxt_r.rdat = 32'h0000_0000;
         if (buf_hit) begin
            nxt_r.rdat[7:0] = r_ff.buffer[buf_sel];
         end else if (idx_a == CSBP_IDX_STAT) begin
            nxt_r.rdat[1:0] = {r_ff.st == CSBP_HOLD, r_ff.busy};
         end else if (idx_a == CSBP_IDX_ISTAT) begin
            nxt_r.rdat[1:0] = r_ff.istat;
         end else if (idx_a == CSBP_IDX_IMASK) begin
            nxt_r.rdat[1:0] = r_ff.imask;
         end
      end

      // Register writes; byte lane zero carries all fields.
      if (wr) begin
         if (buf_hit) begin
            nxt_r.buffer[buf_sel] = dat_i[7:0];
         end else if (idx_a == CSBP_IDX_CTL1) begin
            nxt_r.start  = dat_i[CSBP_C1_START];
            nxt_r.abort  = dat_i[CSBP_C1_ABORT];
            nxt_r.mode   = dat_i[CSBP_C1_MODE +: 3];
            nxt_r.clksel = dat_i[CSBP_C1_CLK +: 3];
         end else if (idx_a == CSBP_IDX_CTL2) begin
            // Taken at any time; software keeps it to stopped or held.
            nxt_r.waitc  = dat_i[CSBP_C2_WAIT +: 2];
            nxt_r.nwords = dat_i[CSBP_C2_WORDS +: 3];
         end else if (idx_a == CSBP_IDX_ISTAT) begin
            nxt_r.istat = r_ff.istat & ~dat_i[1:0];
         end else if (idx_a == CSBP_IDX_IMASK) begin
            nxt_r.imask = dat_i[1:0];
         end
      end

      // A buffer write services a transmit block, a buffer read a receive-only block.
      if (buf_hit && ((wr && is_tx) || (rd && ~we_i && ~is_tx))) begin
         nxt_r.served = 1'b1;
      end

      // Sequencer.
      case (r_ff.st)
         CSBP_IDLE: begin
            nxt_r.sck = 1'b1;
            nxt_r.so  = 1'b1;
            if (go) begin
               // Clock pin idles high and stays high as the block starts.
               nxt_r.busy = 1'b1;
               nxt_r.st   = CSBP_RUN;
               nxt_r.idx  = 3'h0;
               nxt_r.bitc = 3'h0;
               nxt_r.txs  = r_ff.buffer[0];
               nxt_r.div  = 12'h000;
               nxt_r.sck  = 1'b1;
            end
         end
         CSBP_RUN: begin
            if (lead) begin
               nxt_r.sck = 1'b0;
               if (is_tx) begin
                  nxt_r.so  = r_ff.txs[0];
                  nxt_r.txs = {1'b0, r_ff.txs[7:1]};
               end
            end
            if (trail) begin
               nxt_r.sck  = 1'b1;
               nxt_r.rxs  = {si_i, r_ff.rxs[7:1]};
               nxt_r.bitc = r_ff.bitc + 3'h1;
            end
            if (wend) begin
               if (is_rx) begin
                  // Short words land in the top nibble of the shifter.
                  nxt_r.buffer[r_ff.idx] = is_four ?
                     {4'h0, si_i, r_ff.rxs[7:5]} :
                     {si_i, r_ff.rxs[7:1]};
               end
               nxt_r.idx  = nidx;
               nxt_r.bitc = 3'h0;
               nxt_r.txs  = r_ff.buffer[nidx];
               if (!r_ff.start) begin
                  nxt_r.busy = 1'b0;
                  nxt_r.st   = CSBP_IDLE;
               end else if (r_ff.idx == r_ff.nwords) begin
                  // Count stays as written for the next block.
                  nxt_r.istat[CSBP_EV_BLOCK] = 1'b1;
                  nxt_r.served = 1'b0;
                  nxt_r.st     = CSBP_HOLD;
               end else if (!ext && (r_ff.waitc != 2'h0)) begin
                  nxt_r.gap = 7'h00;
                  nxt_r.st  = CSBP_GAP;
               end
            end
         end
         CSBP_GAP: begin
            // Clock rests high while the frame time runs out.
            if (half) begin
               nxt_r.gap = r_ff.gap + 7'h01;
               if (r_ff.gap + 7'h01 >= gaplim) begin
                  nxt_r.st = CSBP_RUN;
               end
            end
         end
         CSBP_HOLD: begin
            // Automatic wait: clock stopped high until software services.
            nxt_r.sck = 1'b1;
            if (!r_ff.start) begin
               nxt_r.busy = 1'b0;
               nxt_r.st   = CSBP_IDLE;
            end else if (r_ff.served) begin
               nxt_r.idx  = 3'h0;
               nxt_r.txs  = r_ff.buffer[0];
               nxt_r.gap  = 7'h00;
               nxt_r.st   = (!ext && (r_ff.waitc != 2'h0)) ? CSBP_GAP : CSBP_RUN;
            end else if (ext && lead) begin
               // An external clock cannot be held; the block gives up.
               nxt_r.busy = 1'b0;
               nxt_r.st   = CSBP_IDLE;
            end
         end
         default: begin
            nxt_r.st = CSBP_IDLE;
         end
      endcase

      // Abort ends everything at once, mid-word included.
      if (r_ff.abort) begin
         nxt_r.busy  = 1'b0;
         nxt_r.st    = CSBP_IDLE;
         nxt_r.sck   = 1'b1;
         nxt_r.so    = 1'b1;
         nxt_r.start = wr && (idx_a == CSBP_IDX_CTL1) ?
                       dat_i[CSBP_C1_START] : 1'b0;
      end

      // End-of-transfer event; set wins over a same-cycle clear.
      if (r_ff.busy && !nxt_r.busy) begin
         nxt_r.istat[CSBP_EV_END] = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff     <= '0;
         r_ff.sck <= 1'b1;
         r_ff.so  <= 1'b1;
         r_ff.sck_prev <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs from flip-flops; irq_o and sck_oe_o through gating on them.
   always_comb begin
      dat_o    = r_ff.rdat;
      ack_o    = r_ff.ack;
      irq_o    = |(r_ff.istat & r_ff.imask);
      so_o     = r_ff.so;
      sck_o    = r_ff.sck;
      sck_oe_o = ~ext;
   end
endmodule : csbp_port
`default_nettype wire

// ==== shared/csbp_pkg.sv ====
// Constants, register map and state types for the buffered clocked serial port.
// Assumes a Wishbone slave with 32-bit data and a 16-bit byte address.
package csbp_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [13:0] CSBP_IDX_ISTAT = 14'h1f90;
   localparam logic [13:0] CSBP_IDX_IMASK = 14'h1f91;
   localparam logic [13:0] CSBP_IDX_STAT  = 14'h1f95;
   localparam logic [13:0] CSBP_IDX_CTL1  = 14'h1f96;
   localparam logic [13:0] CSBP_IDX_CTL2  = 14'h1f97;
   localparam logic [13:0] CSBP_IDX_BUF0  = 14'h1f98;
   localparam logic [13:0] CSBP_IDX_BUF7  = 14'h1f9f;
   // Control register one fields.
   localparam int CSBP_C1_START = 7;
   localparam int CSBP_C1_ABORT = 6;
   localparam int CSBP_C1_MODE  = 3;
   localparam int CSBP_C1_CLK   = 0;
   // Control register two fields.
   localparam int CSBP_C2_WAIT  = 3;
   localparam int CSBP_C2_WORDS = 0;
   // Mode codes.
   localparam logic [2:0] CSBP_M_TX8  = 3'h0;
   localparam logic [2:0] CSBP_M_TX4  = 3'h1;
   localparam logic [2:0] CSBP_M_TRX8 = 3'h4;
   localparam logic [2:0] CSBP_M_RX8  = 3'h5;
   localparam logic [2:0] CSBP_M_RX4  = 3'h6;
   // Clock select code for the external clock pin.
   localparam logic [2:0] CSBP_CLK_EXT = 3'h7;
   // Half-period masks of the divider for codes 0..5: 2^12, then 2^7..2^3 cycles.
   localparam logic [5:0][11:0] CSBP_HALF_MASK = {
      12'h007, 12'h00f, 12'h01f, 12'h03f, 12'h07f, 12'hfff};
   // Half clock periods in one data transfer time of eight bits.
   localparam int CSBP_TD_HALVES = 16;
   // Interrupt status bits: block done, transfer ended.
   localparam int CSBP_EV_BLOCK = 0;
   localparam int CSBP_EV_END   = 1;

   typedef enum logic [1:0] {
      CSBP_IDLE = 2'b00,
      CSBP_RUN  = 2'b01,
      CSBP_GAP  = 2'b10,
      CSBP_HOLD = 2'b11
   } csbp_state_t;

   typedef struct packed {
      logic [7:0][7:0] buffer;   // Shared data buffer.
      logic            start;    // Start bit.
      logic            abort;    // Abort bit, self clearing.
      logic [2:0]      mode;     // Transfer mode.
      logic [2:0]      clksel;   // Clock select.
      logic [1:0]      waitc;    // Frame wait code.
      logic [2:0]      nwords;   // Word count minus one.
      logic            busy;     // Transfer in progress flag.
      csbp_state_t     st;       // Sequencer state.
      logic [2:0]      idx;      // Current buffer word.
      logic [2:0]      bitc;     // Bit within word.
      logic [7:0]      txs;      // Transmit shifter.
      logic [7:0]      rxs;      // Receive shifter.
      logic            sck;      // Driven clock level.
      logic            so;       // Serial data out.
      logic [11:0]     div;      // Rate divider.
      logic [6:0]      gap;      // Frame wait counter.
      logic            served;   // Buffer serviced since block end.
      logic            sck_prev; // Previous external clock level.
      logic [1:0]      istat;    // Sticky interrupt status.
      logic [1:0]      imask;    // Interrupt mask.
      logic            ack;      // Wishbone acknowledge.
      logic [31:0]     rdat;     // Wishbone read data.
   } csbp_regs_t;
endpackage : csbp_pkg
